// ===== verilog/prqfl_pkg.sv
`default_nettype none
package prqfl_pkg;
    localparam int NQ          = 4;
    localparam int QSW         = 2;
    localparam int DW          = 36;
    localparam int START_BIT   = 34;
    localparam int END_BIT     = 35;
    localparam int CODE_HI_BIT = 33;
    localparam int CODE_LO_BIT = 32;
    localparam int RQS_W       = 6;
    localparam int NULL_BIT    = 2;
    localparam int WB_AW       = 8;
    localparam int WB_DW       = 32;
    localparam int LVL_FW      = 8;
    localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] REG_LEVEL  = 8'h04;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h08;
    // Packet counter of queue q sits at REG_PCNT0 + 4*q
    localparam logic [WB_AW-1:0] REG_PCNT0  = 8'h0C;
    localparam int CTRL_PRST_LSB  = 0;
    localparam int CTRL_OWN_BIT   = 4;
    localparam int LVL_AF_LSB     = 0;
    localparam int LVL_AE_LSB     = 8;
    localparam logic [LVL_FW-1:0] AF_LVL_RST = 8'h02;
    localparam logic [LVL_FW-1:0] AE_LVL_RST = 8'h02;
    localparam int STAT_AVAIL_LSB = 0;
    localparam int STAT_EMPTY_LSB = 4;
    localparam int STAT_FULL_LSB  = 8;
    localparam int STAT_PKT_BIT   = 12;
    localparam int STAT_LOOP_BIT  = 13;
endpackage
`default_nettype wire

// ===== verilog/prqfl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prqfl_trk_if #(parameter int CW = 5);
    logic          wrStrobe;
    logic          wrStart;
    logic          wrEnd;
    logic          rdStrobe;
    logic          rdStart;
    logic          rdEnd;
    logic          clear;
    logic          pktAvail;
    logic          rdOpen;
    logic [CW-1:0] pktCount;
    modport ctl (output wrStrobe, wrStart, wrEnd, rdStrobe, rdStart, rdEnd, clear,
                 input pktAvail, rdOpen, pktCount);
    modport trk (input wrStrobe, wrStart, wrEnd, rdStrobe, rdStart, rdEnd, clear,
                 output pktAvail, rdOpen, pktCount);
endinterface

interface prqfl_flag_if #(parameter int N = 4);
    logic [N-1:0] afN;
    logic         loopMode;
    logic         busOwn;
    logic         tokenIn;
    logic [N-1:0] busOut;
    logic         busOeN;
    logic         tokenOut;
    modport ctl (output afN, loopMode, busOwn, tokenIn, input busOut, busOeN, tokenOut);
    modport drv (input afN, loopMode, busOwn, tokenIn, output busOut, busOeN, tokenOut);
endinterface
`default_nettype wire

// ===== verilog/prqfl_pkt_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module prqfl_pkt_tracker #(
    parameter int CW = 5
) (
    input  wire logic  ref_clk,
    input  wire logic  srst,
    prqfl_trk_if.trk   trk
);
    logic          wrIn_r;
    logic          rdOpen_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    wire wrOpenEv  = trk.wrStrobe && trk.wrStart && !wrIn_r;
    wire wrCloseEv = trk.wrStrobe && trk.wrEnd && wrIn_r;
    wire rdTakeEv  = trk.rdStrobe && trk.rdStart && !rdOpen_r;
    wire rdDoneEv  = trk.rdStrobe && trk.rdEnd && rdOpen_r;

    // Up on a closed packet, down when its start leaves the queue
    assign count_nxt = count_r + CW'(wrCloseEv) - CW'(rdTakeEv);

    always_ff @(posedge ref_clk) begin
        if (srst || trk.clear) begin
            wrIn_r   <= 1'b0;
            rdOpen_r <= 1'b0;
            count_r  <= '0;
        end else begin
            wrIn_r   <= wrCloseEv ? 1'b0 : (wrIn_r || wrOpenEv);
            rdOpen_r <= rdDoneEv ? 1'b0 : (rdOpen_r || rdTakeEv);
            count_r  <= count_nxt;
        end
    end

    assign trk.pktAvail = (count_r != '0);
    assign trk.rdOpen   = rdOpen_r;
    assign trk.pktCount = count_r;

    sequence sqClose;
        wrCloseEv && !rdTakeEv && !trk.clear;
    endsequence
    sequence sqTake;
        rdTakeEv && !wrCloseEv && !trk.clear;
    endsequence
    AST_CLOSE_COUNTS: assert property (@(posedge ref_clk) disable iff (srst)
        sqClose |=> count_r == $past(count_r) + CW'(1))
        else $error("packet close did not raise the counter");
    AST_READ_START_MARKER_DROPS: assert property (@(posedge ref_clk) disable iff (srst)
        sqTake |=> count_r == $past(count_r) - CW'(1))
        else $error("read start did not lower the counter");
    AST_SECOND_EOP: assert property (@(posedge ref_clk) disable iff (srst)
        (trk.wrStrobe && trk.wrEnd && !wrIn_r && !rdTakeEv && !trk.clear)
        |=> $stable(count_r))
        else $error("repeated end marker changed counter");
    AST_SECOND_SOP: assert property (@(posedge ref_clk) disable iff (srst)
        (wrIn_r && trk.wrStrobe && trk.wrStart && !trk.wrEnd && !trk.clear) |=> wrIn_r)
        else $error("repeated start marker restarted packet");
    AST_CLEAR_EMPTY: assert property (@(posedge ref_clk)
        (srst || trk.clear) |=> (count_r == '0) && !rdOpen_r && !wrIn_r)
        else $error("clear left packet state");
endmodule
`default_nettype wire

// ===== verilog/prqfl_flag_bus.sv
`timescale 1ns/1ps
`default_nettype none
module prqfl_flag_bus (
    input  wire logic  ref_clk,
    input  wire logic  srst,
    prqfl_flag_if.drv  fl
);
    logic       tokS1_r;
    logic       tokS2_r;
    logic [3:0] busOut_r;
    logic       busOeN_r;
    logic       tokOut_r;
    // Looped: hold the bus while the token is here. Addressed: software owns it.
    wire drive = fl.loopMode ? tokS2_r : fl.busOwn;

    always_ff @(posedge ref_clk) begin
        tokS1_r <= fl.tokenIn;
        tokS2_r <= tokS1_r;
        if (srst) begin
            busOut_r <= '1;
            busOeN_r <= 1'b1;
            tokOut_r <= 1'b0;
        end else begin
            busOut_r <= fl.afN;
            busOeN_r <= !drive;
            tokOut_r <= fl.loopMode && tokS2_r;
        end
    end

    assign fl.busOut   = busOut_r;
    assign fl.busOeN   = busOeN_r;
    assign fl.tokenOut = tokOut_r;

    AST_SINGLE_DRIVER: assert property (@(posedge ref_clk) disable iff (srst)
        !drive |=> busOeN_r)
        else $error("bus driven without ownership");
endmodule
`default_nettype wire

// ===== verilog/prqfl_top.sv
`timescale 1ns/1ps
`default_nettype none
module prqfl_top
    import prqfl_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              wbCycI,
    input  wire logic              wbStbI,
    input  wire logic              wbWeI,
    input  wire logic [WB_AW-1:0]  wbAdrI,
    input  wire logic [3:0]        wbSelI,
    input  wire logic [WB_DW-1:0]  wbDatI,
    output logic      [WB_DW-1:0]  wbDatO,
    output logic                   wbAckO,
    input  wire logic              wrEnN,
    input  wire logic [QSW-1:0]    wrQueue,
    input  wire logic [DW-1:0]     wrData,
    output logic                   fullN,
    input  wire logic              rdEnN,
    input  wire logic [RQS_W-1:0]  readQueueSelect,
    output logic      [DW-1:0]     rdData,
    output logic                   readValidN,
    output logic                   packetReadyN,
    output logic      [NQ-1:0]     almostEmptyBus,
    output logic      [NQ-1:0]     almostFullBus,
    output logic                   almostFullBusOeN,
    input  wire logic              flagTokenIn,
    output logic                   flagTokenOut,
    input  wire logic              packetModePin,
    input  wire logic              flagBusMode
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int LW = CW + LVL_FW;

    // Straps pass a synchroniser, then are caught while reset is held
    logic              pktS1_r;
    logic              pktS2_r;
    logic              fmS1_r;
    logic              fmS2_r;
    logic              pktMode_r;
    logic              loopMode_r;

    logic [DW-1:0]     mem [NQ*DEPTH];
    logic [AW-1:0]     wrPtr_r [NQ];
    logic [AW-1:0]     rdPtr_r [NQ];
    logic [CW-1:0]     cnt_r   [NQ];

    logic [NQ-1:0]     prst_r;
    logic              busOwn_r;
    logic [LVL_FW-1:0] afLvl_r;
    logic [LVL_FW-1:0] aeLvl_r;
    logic              ack_r;
    logic [WB_DW-1:0]  datO_r;

    logic [DW-1:0]     rdData_r;
    logic              readValidN_r;
    logic              packetReadyN_r;
    logic [NQ-1:0]     aeBus_r;
    logic              fullN_r;

    logic [NQ-1:0]     fullV;
    logic [NQ-1:0]     emptyV;
    logic [NQ-1:0]     afNV;
    logic [NQ-1:0]     aeNV;
    logic [NQ-1:0]     availV;
    logic [NQ-1:0]     openV;
    logic [NQ-1:0]     readableV;
    logic [CW-1:0]     pcntV [NQ];

    always_ff @(posedge ref_clk) begin
        pktS1_r <= packetModePin;
        pktS2_r <= pktS1_r;
        fmS1_r  <= flagBusMode;
        fmS2_r  <= fmS1_r;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pktMode_r  <= pktS2_r;
            loopMode_r <= fmS2_r;
        end
    end

    // Write port: the queue address has no null decode at all
    wire wrFire = !wrEnN && !fullV[wrQueue];
    wire [QSW+AW-1:0] wrAddr = {wrQueue, wrPtr_r[wrQueue]};

    always_ff @(posedge ref_clk) begin
        if (wrFire) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Read port selection
    wire              isNull = readQueueSelect[NULL_BIT];
    wire [QSW-1:0]    rdQ    = readQueueSelect[QSW-1:0];
    wire [DW-1:0]     memWord = mem[{rdQ, rdPtr_r[rdQ]}];
    wire              canPop = !isNull && readableV[rdQ];
    // Refill when the word is taken or the output holds nothing valid
    wire              needWord = !rdEnN || readValidN_r;
    wire              pop = canPop && needWord;
    wire              availSel = availV[rdQ];
    wire              openSel  = openV[rdQ];

    genvar q;
    generate
        for (q = 0; q < NQ; q++) begin : g_queue
            prqfl_trk_if #(.CW(CW)) trkIf ();
            wire wrHit = wrFire && (wrQueue == QSW'(q));
            wire rdHit = pop && (rdQ == QSW'(q));

            always_ff @(posedge ref_clk) begin
                if (srst || prst_r[q]) begin
                    wrPtr_r[q] <= '0;
                    rdPtr_r[q] <= '0;
                    cnt_r[q]   <= '0;
                end else begin
                    wrPtr_r[q] <= wrPtr_r[q] + AW'(wrHit);
                    rdPtr_r[q] <= rdPtr_r[q] + AW'(rdHit);
                    cnt_r[q]   <= cnt_r[q] + CW'(wrHit) - CW'(rdHit);
                end
            end

            assign fullV[q]  = (cnt_r[q] == CW'(DEPTH));
            assign emptyV[q] = (cnt_r[q] == '0);
            assign afNV[q]   = !((LW'(cnt_r[q]) + LW'(afLvl_r)) >= LW'(DEPTH));
            assign aeNV[q]   = !(LW'(cnt_r[q]) <= LW'(aeLvl_r));
            // Packet mode: only complete packets, or the rest of one in progress
            assign readableV[q] = !emptyV[q] &&
                                  (!pktMode_r || availV[q] || openV[q]);

            assign trkIf.wrStrobe = wrHit;
            assign trkIf.wrStart  = wrData[START_BIT];
            assign trkIf.wrEnd    = wrData[END_BIT];
            assign trkIf.rdStrobe = rdHit;
            assign trkIf.rdStart  = memWord[START_BIT];
            assign trkIf.rdEnd    = memWord[END_BIT];
            assign trkIf.clear    = prst_r[q];
            assign availV[q]      = trkIf.pktAvail;
            assign openV[q]       = trkIf.rdOpen;
            assign pcntV[q]       = trkIf.pktCount;

            prqfl_pkt_tracker #(.CW(CW)) u_trk (
                .ref_clk (ref_clk),
                .srst    (srst),
                .trk     (trkIf)
            );
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdData_r     <= '0;
            readValidN_r <= 1'b1;
        end else if (pop) begin
            rdData_r     <= memWord;
            readValidN_r <= 1'b0;
        end else if (needWord || isNull) begin
            // Data stays put; only validity drops. The null queue counts as
            // empty, so validity drops there even while reads are held off.
            readValidN_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            packetReadyN_r <= 1'b1;
            aeBus_r        <= '1;
            fullN_r        <= 1'b1;
        end else begin
            packetReadyN_r <= !(pktMode_r && !isNull && availSel);
            aeBus_r        <= pktMode_r ? ~availV : aeNV;
            fullN_r        <= !fullV[wrQueue];
        end
    end

    // Almost-full bus drive and sharing
    prqfl_flag_if #(.N(NQ)) flagIf ();
    assign flagIf.afN      = afNV;
    assign flagIf.loopMode = loopMode_r;
    assign flagIf.busOwn   = busOwn_r;
    assign flagIf.tokenIn  = flagTokenIn;

    prqfl_flag_bus u_flag (
        .ref_clk (ref_clk),
        .srst    (srst),
        .fl      (flagIf)
    );

    // Wishbone register slave: one wait state, unmapped reads return zero
    wire                  wbReq    = wbCycI && wbStbI && !ack_r;
    wire                  wbWr     = wbReq && wbWeI;
    wire                  selCtrl  = (wbAdrI == REG_CTRL);
    wire                  selLevel = (wbAdrI == REG_LEVEL);
    wire                  selStat  = (wbAdrI == REG_STATUS);
    wire [WB_AW-1:0]      pcOff    = wbAdrI - REG_PCNT0;
    wire                  selPcnt  = (wbAdrI >= REG_PCNT0) &&
                                     (pcOff[WB_AW-1:2] < (WB_AW-2)'(NQ));
    wire [QSW-1:0]        pcIdx    = pcOff[QSW+1:2];
    wire [WB_DW-1:0]      ctrlWord = WB_DW'(busOwn_r) << CTRL_OWN_BIT;
    wire [WB_DW-1:0]      lvlWord  = (WB_DW'(afLvl_r) << LVL_AF_LSB) |
                                     (WB_DW'(aeLvl_r) << LVL_AE_LSB);
    wire [WB_DW-1:0]      statWord = (WB_DW'(availV) << STAT_AVAIL_LSB) |
                                     (WB_DW'(emptyV) << STAT_EMPTY_LSB) |
                                     (WB_DW'(fullV)  << STAT_FULL_LSB)  |
                                     (WB_DW'(pktMode_r)  << STAT_PKT_BIT) |
                                     (WB_DW'(loopMode_r) << STAT_LOOP_BIT);
    wire [WB_DW-1:0]      rdMux    = selCtrl  ? ctrlWord :
                                     selLevel ? lvlWord  :
                                     selStat  ? statWord :
                                     selPcnt  ? WB_DW'(pcntV[pcIdx]) : '0;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_r  <= 1'b0;
            datO_r <= '0;
        end else begin
            ack_r  <= wbReq;
            datO_r <= wbReq ? rdMux : datO_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prst_r   <= '0;
            busOwn_r <= 1'b0;
            afLvl_r  <= AF_LVL_RST;
            aeLvl_r  <= AE_LVL_RST;
        end else begin
            prst_r <= (wbWr && selCtrl && wbSelI[0]) ?
                      wbDatI[CTRL_PRST_LSB +: NQ] : '0;
            if (wbWr && selCtrl && wbSelI[0]) begin
                busOwn_r <= wbDatI[CTRL_OWN_BIT];
            end
            if (wbWr && selLevel && wbSelI[0]) begin
                afLvl_r <= wbDatI[LVL_AF_LSB +: LVL_FW];
            end
            if (wbWr && selLevel && wbSelI[1]) begin
                aeLvl_r <= wbDatI[LVL_AE_LSB +: LVL_FW];
            end
        end
    end

    assign wbAckO           = ack_r;
    assign wbDatO           = datO_r;
    assign fullN            = fullN_r;
    assign rdData           = rdData_r;
    assign readValidN       = readValidN_r;
    assign packetReadyN     = packetReadyN_r;
    assign almostEmptyBus   = aeBus_r;
    assign almostFullBus    = flagIf.busOut;
    assign almostFullBusOeN = flagIf.busOeN;
    assign flagTokenOut     = flagIf.tokenOut;

    sequence sqPopTaken;
        pop ##1 !readValidN_r;
    endsequence

    AST_POP_DELIVERS: assert property (@(posedge ref_clk) disable iff (srst)
        pop |-> sqPopTaken)
        else $error("popped word not presented as valid");
    AST_BYTE_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        pop |=> rdData_r[CODE_HI_BIT:CODE_LO_BIT] == $past(memWord[CODE_HI_BIT:CODE_LO_BIT]))
        else $error("byte code bits altered");
    AST_PKT_GATE: assert property (@(posedge ref_clk) disable iff (srst)
        (pktMode_r && !isNull && !availSel && !openSel) |=> $stable(rdData_r))
        else $error("word left queue without complete packet");
    AST_NULL_HOLDS: assert property (@(posedge ref_clk) disable iff (srst)
        (isNull && !rdEnN) |=> readValidN_r && $stable(rdData_r))
        else $error("null queue disturbed output");
    AST_FALLTHROUGH: assert property (@(posedge ref_clk) disable iff (srst)
        (readValidN_r && canPop) |=> !readValidN_r)
        else $error("last word did not fall through");
    AST_PR_LOW: assert property (@(posedge ref_clk) disable iff (srst)
        (pktMode_r && !isNull && availSel) |=> !packetReadyN_r)
        else $error("packet ready not asserted");
    AST_AE_BUS: assert property (@(posedge ref_clk) disable iff (srst)
        pktMode_r |=> almostEmptyBus == ~$past(availV))
        else $error("almost-empty bus not showing packet ready");
    AST_WB_ACK: assert property (@(posedge ref_clk) disable iff (srst)
        (wbCycI && wbStbI && !wbAckO) |=> wbAckO ##1 !wbAckO)
        else $error("wishbone ack not single cycle");

    // Null queue: an empty queue on the read side, invisible to the write side
    sequence sqNullWrite;
        isNull && wrFire && !(|prst_r);
    endsequence

    AST_NULL_IDLE: assert property (@(posedge ref_clk) disable iff (srst)
        (isNull && rdEnN) |=> readValidN_r && $stable(rdData_r))
        else $error("null queue kept output valid");
    AST_NULL_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
        sqNullWrite |=> !(&emptyV))
        else $error("write lost while null queue selected");
    AST_PR_PARTIAL: assert property (@(posedge ref_clk) disable iff (srst)
        (pktMode_r && !availSel) |=> packetReadyN_r)
        else $error("packet ready shown without a complete packet");
    AST_PR_STD: assert property (@(posedge ref_clk) disable iff (srst)
        !pktMode_r |=> packetReadyN_r)
        else $error("packet ready asserted in standard mode");
    // Once a packet has started leaving, its remaining words are never held back
    AST_OPEN_FLOWS: assert property (@(posedge ref_clk) disable iff (srst)
        (pktMode_r && needWord && !isNull && openSel && !emptyV[rdQ]) |-> pop)
        else $error("open packet stalled");
    AST_STD_STREAM: assert property (@(posedge ref_clk) disable iff (srst)
        (!pktMode_r && needWord && !isNull && !emptyV[rdQ]) |-> pop)
        else $error("standard mode read stalled");
    AST_FULL_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
        fullV[wrQueue] |=> !fullN_r)
        else $error("full queue not flagged");
endmodule
`default_nettype wire

// ===== bench/prqfl_writer_model.sv
`timescale 1ns/1ps
`default_nettype none
module prqfl_writer_model
    import prqfl_pkg::*;
(
    input  wire logic           ref_clk,
    output logic                wrEnN,
    output logic [QSW-1:0]      wrQueue,
    output logic [DW-1:0]       wrData
);
    initial begin
        wrEnN = 1'b1;
        wrQueue = '0;
        wrData = '0;
    end
    // Whole 36-bit word per edge, markers ride on the word they tag
    task automatic put(input logic [QSW-1:0] q, input logic [DW-1:0] w);
        @(posedge ref_clk);
        wrEnN <= 1'b0;
        wrQueue <= q;
        wrData <= w;
    endtask
    // Idle bus flips so a stale word can never be mistaken for a write
    task automatic idle();
        @(posedge ref_clk);
        wrEnN <= 1'b1;
        wrData <= ~wrData;
    endtask
endmodule
`default_nettype wire

// ===== bench/test_packet_ready_and_queue_flag_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_packet_ready_and_queue_flag_logic;
    import prqfl_pkg::*;
    logic ref_clk = 0, srst = 1, wbCycI = 0, wbStbI = 0, wbWeI = 0, rdEnN = 1;
    logic [WB_AW-1:0] wbAdrI = '0;
    logic [3:0] wbSelI = '0;
    logic [WB_DW-1:0] wbDatI = '0, rd;
    logic [RQS_W-1:0] readQueueSelect = 6'b00_0100;
    logic packetModePin = 1, flagBusMode = 0, flagTokenIn = 0;
    wire logic [WB_DW-1:0] wbDatO;
    wire logic wbAckO, fullN, readValidN, packetReadyN, almostFullBusOeN, flagTokenOut;
    wire logic wrEnN;
    wire logic [QSW-1:0] wrQueue;
    wire logic [DW-1:0] wrData, rdData;
    wire logic [NQ-1:0] almostEmptyBus, almostFullBus;
    int failures = 0, samples_checked = 0, i, prLow = 0;
    integer seed = 32'h6cf1_3272;
    logic [DW-1:0] exp[$], got[$];
    always #5 ref_clk = ~ref_clk;
    prqfl_top #(.DEPTH(8)) dut_u (.ref_clk(ref_clk), .srst(srst), .wbCycI(wbCycI),
        .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
        .wbDatO(wbDatO), .wbAckO(wbAckO), .wrEnN(wrEnN), .wrQueue(wrQueue),
        .wrData(wrData), .fullN(fullN), .rdEnN(rdEnN), .readQueueSelect(readQueueSelect),
        .rdData(rdData), .readValidN(readValidN), .packetReadyN(packetReadyN),
        .almostEmptyBus(almostEmptyBus), .almostFullBus(almostFullBus),
        .almostFullBusOeN(almostFullBusOeN), .flagTokenIn(flagTokenIn),
        .flagTokenOut(flagTokenOut), .packetModePin(packetModePin),
        .flagBusMode(flagBusMode));
    prqfl_writer_model model_u (.ref_clk(ref_clk), .wrEnN(wrEnN), .wrQueue(wrQueue),
        .wrData(wrData));
    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] e);
        samples_checked++;
        if (seen !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d);
        @(posedge ref_clk);
        wbCycI <= 1'b1;
        wbStbI <= 1'b1;
        wbWeI <= we;
        wbSelI <= 4'hF;
        wbAdrI <= a;
        wbDatI <= d;
        do @(posedge ref_clk); while (wbAckO !== 1'b1);
        rd = wbDatO;
        wbCycI <= 1'b0;
        wbStbI <= 1'b0;
        wbSelI <= 4'h0;
    endtask
    // Random payload and byte code; code bits 33:32 are taken from the random draw like the payload
    function automatic logic [DW-1:0] mk(input logic s, input logic e);
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return {e, s, r[33:0]};
    endfunction
    task automatic put(input logic s, input logic e, input bit keep);
        logic [DW-1:0] w;
        w = mk(s, e);
        if (keep)
            exp.push_back(w);
        model_u.put(2'd0, w);
    endtask
    task automatic waitAe(input logic lvl);
        for (i = 0; i < 30 && almostEmptyBus[0] !== lvl; i++)
            @(posedge ref_clk);
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        rdEnN <= 1'b0;
        @(posedge ref_clk);
        check("readValidN", readValidN, 1);
        check("packetReadyN", packetReadyN, 1);
        wb(0, REG_STATUS, 0);
        check("pktMode", rd[STAT_PKT_BIT], 1);
        wb(0, 8'hF0, 0);
        check("unmapped", rd, 0);
        // Null queue picked with junk in the ignored upper bits; packet lands in queue 0
        readQueueSelect <= 6'b10_1100;
        put(1, 0, 1);
        put(1, 0, 1);
        put(0, 0, 1);
        model_u.idle();
        repeat (8) @(posedge ref_clk);
        check("aeBusPartial", almostEmptyBus[0], 1);
        wb(0, REG_PCNT0, 0);
        check("countPartial", rd, 0);
        put(0, 1, 1);
        put(0, 1, 0);
        model_u.idle();
        waitAe(1'b0);
        check("aeBusReady", almostEmptyBus[0], 0);
        check("nullValid", readValidN, 1);
        wb(0, REG_PCNT0, 0);
        check("countOne", rd, 1);
        put(1, 0, 0);
        put(0, 0, 0);
        put(0, 0, 0);
        model_u.idle();
        repeat (2) @(posedge ref_clk);
        check("fullAtDepth", fullN, 0);
        readQueueSelect <= 6'b00_0000;
        repeat (20) begin
            @(posedge ref_clk);
            if (packetReadyN === 1'b0 && readValidN === 1'b0)
                prLow++;
            if (readValidN === 1'b0)
                got.push_back(rdData);
        end
        check("prWithValid", prLow != 0, 1);
        check("wordsRead", got.size(), exp.size());
        foreach (exp[k])
            check("word", got[k], exp[k]);
        check("prAfterRead", packetReadyN, 1);
        wb(0, REG_PCNT0, 0);
        check("countZero", rd, 0);
        readQueueSelect <= 6'b00_0100;
        repeat (4) @(posedge ref_clk);
        check("nullHold", rdData, exp[exp.size()-1]);
        check("nullValidN", readValidN, 1);
        put(0, 1, 0);
        model_u.idle();
        waitAe(1'b0);
        check("aeBusSecond", almostEmptyBus[0], 0);
        wb(1, REG_CTRL, 32'h0000_0001);
        waitAe(1'b1);
        check("aeBusCleared", almostEmptyBus[0], 1);
        wb(1, REG_CTRL, 32'h0000_0010);
        repeat (3) @(posedge ref_clk);
        check("afOe", almostFullBusOeN, 0);
        check("afBus", almostFullBus, 4'hF);
        check("tokIdle", flagTokenOut, 0);
        // Second reset mid-run: standard mode, looped flag bus
        srst <= 1'b1;
        packetModePin <= 1'b0;
        flagBusMode <= 1'b1;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        check("rstOe", almostFullBusOeN, 1);
        check("rstData", rdData, 0);
        wb(0, REG_STATUS, 0);
        check("stdMode", rd[STAT_PKT_BIT], 0);
        check("loopMode", rd[STAT_LOOP_BIT], 1);
        flagTokenIn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("tokOe", almostFullBusOeN, 0);
        check("tokOut", flagTokenOut, 1);
        flagTokenIn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("tokOff", almostFullBusOeN, 1);
        exp.delete();
        repeat (3) begin
            exp.push_back(mk(0, 0));
            model_u.put(2'd1, exp[exp.size()-1]);
        end
        model_u.idle();
        rdEnN <= 1'b1;
        readQueueSelect <= 6'b00_0001;
        repeat (3) @(posedge ref_clk);
        check("fallThrough", rdData, exp[0]);
        check("fallValid", readValidN, 0);
        readQueueSelect <= 6'b00_0100;
        repeat (2) @(posedge ref_clk);
        check("nullIdle", readValidN, 1);
        check("nullIdleData", rdData, exp[0]);
        rdEnN <= 1'b0;
        readQueueSelect <= 6'b00_0001;
        @(posedge ref_clk);
        for (i = 1; i < 3; i++) begin
            @(posedge ref_clk);
            check("stdWord", rdData, exp[i]);
            check("stdValid", readValidN, 0);
        end
        @(posedge ref_clk);
        check("stdEmpty", readValidN, 1);
        check("stdPr", packetReadyN, 1);
        summarize();
    end
endmodule
`default_nettype wire
